/* File: logic/uef_defs.svh */
// Offsets, field positions, reset values and timing counts of the error flag block
`ifndef UEF_DEFS_SVH
`define UEF_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define UEF_ADDR_W 8
`define UEF_OFF_FLAGS 8'h00
`define UEF_OFF_CTRL 8'h04
`define UEF_OFF_STATUS 8'h08

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define UEF_BIT_STUFF 7
`define UEF_BIT_BUS_MATRIX 6
`define UEF_BIT_MEM_XFER 5
`define UEF_BIT_TURNAROUND 4
`define UEF_BIT_PARTIAL 3
`define UEF_BIT_PAYLOAD_CRC 2
`define UEF_BIT_MODE_DEP 1
`define UEF_BIT_PID 0
`define UEF_FLAG_W 8

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define UEF_CTRL_HOST_MODE 0
`define UEF_STAT_TA_WAIT 0
`define UEF_STAT_FRAME_BUSY 1

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define UEF_FLAGS_RESET 8'h00
`define UEF_CTRL_RESET 1'h0
`define UEF_TURNAROUND_BIT_TIMES 16

`endif

/* File: logic/uef_error_flags.sv */
// Error status flag register of the USB controller
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "uef_defs.svh"

// Functional notes
// (RULE1) Bits 31 down to 8 of the flag register read as zero.
// (RULE2) Flags set by hardware, zero at reset, cleared only by writing one.
// (RULE3) Bit stuff violation sets bit 7 and discards the packet.
// (RULE4) Invalid descriptor table base or buffer address sets bit 6.
// (RULE5) Late memory grant or truncated packet sets bit 5.
// (RULE6) Over sixteen idle bit times after end of packet sets bit 4.
// (RULE7) Data field not whole bytes sets bit 3.
// (RULE8) CRC16 failure sets bit 2 and rejects the data packet.
// (RULE9) Bit 1: frame end error in host mode, CRC5 error in device mode.
// (RULE10) Bad identifier complement sets bit 0; CRC5 failure sets bit 1 in device.
module uef_error_flags #(
  parameter int SOF_W = 16
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [`UEF_ADDR_W-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // Packet receiver events
  input wire uef_pkg::uef_rx_evt_t i_rx,
  input wire logic i_bit_tick,
  // Memory transfer events
  input wire uef_pkg::uef_dma_evt_t i_dma,
  // Frame timing
  input wire logic [SOF_W-1:0] i_sof_count,
  input wire logic i_xfer_busy,
  // Results
  output logic o_packet_reject,
  output logic o_host_mode,
  output logic [`UEF_FLAG_W-1:0] o_flags
);

  if (SOF_W < 2)
  begin : g_bad_sof
    $error("uef_error_flags: SOF_W must be at least 2");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [`UEF_FLAG_W-1:0] usb_error_flags;
  logic host_mode;
  logic [`UEF_FLAG_W-1:0] flag_set;
  logic [`UEF_FLAG_W-1:0] flag_clr;
  logic [SOF_W-1:0] sof_prev;
  logic eof_err;
  logic ta_waiting;
  logic ta_timeout;
  logic pid_err;
  logic wr_flags;
  logic wr_ctrl;
  logic [31:0] next_rdata;
  // Reset image kept as a vector so each flop takes exactly its own bit
  localparam logic [`UEF_FLAG_W-1:0] FLAGS_RESET = `UEF_FLAGS_RESET;

  assign wr_flags = i_reg_wr && (i_reg_addr == `UEF_OFF_FLAGS);
  assign wr_ctrl = i_reg_wr && (i_reg_addr == `UEF_OFF_CTRL);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  uef_turnaround_timer #(
    .LIMIT(`UEF_TURNAROUND_BIT_TIMES),
    .CNT_W(5)
  ) u_turnaround (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_start(i_rx.eop && i_rx.expect_reply),
    .i_activity(i_rx.sop),
    .i_bit_tick(i_bit_tick),
    .o_waiting(ta_waiting),
    .o_timeout(ta_timeout)
  );

  uef_pid_checker u_pid (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_pid_valid(i_rx.pid_valid),
    .i_pid(i_rx.pid),
    .o_pid_err(pid_err)
  );

  // ----------------------------------------
  // Frame end detection
  // ----------------------------------------
  // Only the step into zero counts, so a counter parked at zero raises one event
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      sof_prev <= '0;
    else
      sof_prev <= i_sof_count;
  end

  // (RULE9) busy as frame counter hits zero
  assign eof_err = host_mode && i_xfer_busy && (i_sof_count == '0) && (sof_prev != '0);

  // ----------------------------------------
  // Set sources
  // ----------------------------------------
  always_comb
  begin
    flag_set = '0;
    // (RULE3) stuff error
    flag_set[`UEF_BIT_STUFF] = i_rx.stuff_err;
    // (RULE4) address invalid
    flag_set[`UEF_BIT_BUS_MATRIX] = i_dma.bdt_base_invalid || i_dma.buf_addr_invalid;
    // (RULE5) late grant or truncation
    flag_set[`UEF_BIT_MEM_XFER] = i_dma.grant_late || i_rx.truncated;
    // (RULE6) turnaround time-out
    flag_set[`UEF_BIT_TURNAROUND] = ta_timeout;
    // (RULE7) partial byte
    flag_set[`UEF_BIT_PARTIAL] = i_rx.partial_byte;
    // (RULE8) payload CRC
    flag_set[`UEF_BIT_PAYLOAD_CRC] = i_rx.crc16_fail;
    // (RULE9) mode dependent bit
    flag_set[`UEF_BIT_MODE_DEP] = host_mode ? eof_err : i_rx.crc5_fail;
    // (RULE10) identifier check
    flag_set[`UEF_BIT_PID] = pid_err;
  end

  assign flag_clr = wr_flags ? i_reg_wdata[`UEF_FLAG_W-1:0] : '0;

  // ----------------------------------------
  // Flag storage
  // ----------------------------------------
  // Set beats clear in the same cycle so no event is lost to a racing write
  for (genvar b = 0; b < `UEF_FLAG_W; b++)
  begin : g_flag
    // (RULE2) sticky write-one-to-clear
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
      if (!i_resetn)
        usb_error_flags[b] <= FLAGS_RESET[b];
      else if (flag_set[b])
        usb_error_flags[b] <= 1'b1;
      else if (flag_clr[b])
        usb_error_flags[b] <= 1'b0;
    end
  end

  assign o_flags = usb_error_flags;

  // ----------------------------------------
  // Control register and packet reject
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      host_mode <= `UEF_CTRL_RESET;
    else if (wr_ctrl)
      host_mode <= i_reg_wdata[`UEF_CTRL_HOST_MODE];
  end

  assign o_host_mode = host_mode;

  // (RULE3) (RULE8) drop the packet
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_packet_reject <= 1'b0;
    else
      o_packet_reject <= i_rx.stuff_err || i_rx.crc16_fail;
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Data only in the cycle after the strobe; unmapped offsets read zero
  always_comb
  begin
    next_rdata = '0;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        // (RULE1) upper bits zero
        `UEF_OFF_FLAGS: next_rdata[`UEF_FLAG_W-1:0] = usb_error_flags;
        `UEF_OFF_CTRL: next_rdata[`UEF_CTRL_HOST_MODE] = host_mode;
        `UEF_OFF_STATUS:
        begin
          next_rdata[`UEF_STAT_TA_WAIT] = ta_waiting;
          next_rdata[`UEF_STAT_FRAME_BUSY] = i_xfer_busy;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_reg_rdata <= '0;
    else
      o_reg_rdata <= next_rdata;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_flag_read;
    i_reg_rd && i_reg_addr == `UEF_OFF_FLAGS;
  endsequence

  sequence s_clear_bit(int b);
    wr_flags && i_reg_wdata[b] && !flag_set[b];
  endsequence

  // Stuff event landing on a write that clears the same bit
  sequence s_set_and_clear;
    i_rx.stuff_err && wr_flags && i_reg_wdata[`UEF_BIT_STUFF];
  endsequence

  sequence s_unmapped_read;
    i_reg_rd && (i_reg_addr != `UEF_OFF_FLAGS) && (i_reg_addr != `UEF_OFF_CTRL)
      && (i_reg_addr != `UEF_OFF_STATUS);
  endsequence

  AST_UPPER_ZERO: assert property (s_flag_read |=> o_reg_rdata[31:8] == 24'h000000) // RULE1
    else $error("upper flag bits not zero");

  AST_READ_VALUE: assert property (s_flag_read |=> o_reg_rdata[7:0] == $past(usb_error_flags)) // RULE2
    else $error("flag read mismatch");

  AST_W1C_CLEARS: assert property (s_clear_bit(`UEF_BIT_PARTIAL) |=> !usb_error_flags[`UEF_BIT_PARTIAL]) // RULE2
    else $error("write one did not clear flag");

  AST_STICKY: assert property (usb_error_flags[`UEF_BIT_STUFF] && !(wr_flags && i_reg_wdata[`UEF_BIT_STUFF])
    |=> usb_error_flags[`UEF_BIT_STUFF]) // RULE2
    else $error("flag dropped without write");

  AST_STUFF_DISCARD: assert property (i_rx.stuff_err && wr_flags |=> usb_error_flags[`UEF_BIT_STUFF]
    && o_packet_reject) // RULE3
    else $error("stuff error not latched or packet kept");

  AST_ADDR_ERR: assert property (i_dma.buf_addr_invalid |=> usb_error_flags[`UEF_BIT_BUS_MATRIX]) // RULE4
    else $error("address error not latched");

  AST_MEM_XFER: assert property (i_rx.truncated || i_dma.grant_late |=> usb_error_flags[`UEF_BIT_MEM_XFER]) // RULE5
    else $error("memory transfer error not latched");

  AST_TURNAROUND: assert property (ta_timeout |=> usb_error_flags[`UEF_BIT_TURNAROUND]) // RULE6
    else $error("turnaround time-out not latched");

  AST_PARTIAL: assert property (!usb_error_flags[`UEF_BIT_PARTIAL] && !i_rx.partial_byte
    |=> !usb_error_flags[`UEF_BIT_PARTIAL]) // RULE7
    else $error("partial byte flag set without cause");

  AST_CRC16_REJECT: assert property (i_rx.crc16_fail |=> o_packet_reject ##0
    usb_error_flags[`UEF_BIT_PAYLOAD_CRC]) // RULE8
    else $error("payload check failure not handled");

  AST_EOF_HOST: assert property (host_mode && i_xfer_busy && $fell(|i_sof_count)
    |=> usb_error_flags[`UEF_BIT_MODE_DEP]) // RULE9
    else $error("frame end error missed");

  AST_CRC5_DEVICE: assert property (!host_mode && i_rx.crc5_fail |=> usb_error_flags[`UEF_BIT_MODE_DEP]) // RULE10
    else $error("token check error missed");

  AST_PID_LATCH: assert property (pid_err |=> usb_error_flags[`UEF_BIT_PID]) // RULE10
    else $error("identifier error not latched");

  AST_BASE_ERR: assert property (i_dma.bdt_base_invalid |=> usb_error_flags[`UEF_BIT_BUS_MATRIX]) // RULE4
    else $error("table base error not latched");

  AST_PARTIAL_SET: assert property (i_rx.partial_byte |=> usb_error_flags[`UEF_BIT_PARTIAL]) // RULE7
    else $error("partial byte flag not latched");

  AST_PACKET_KEEP: assert property (!i_rx.stuff_err && !i_rx.crc16_fail |=> !o_packet_reject) // RULE8
    else $error("clean packet rejected");

  AST_SET_WINS: assert property (s_set_and_clear |=> usb_error_flags[`UEF_BIT_STUFF]) // RULE2
    else $error("clear beat a same-cycle set");

  // A token check failure in host mode must not leak into the frame end bit
  AST_HOST_NO_CRC5: assert property (host_mode && i_rx.crc5_fail && !i_xfer_busy // RULE9
    && !usb_error_flags[`UEF_BIT_MODE_DEP] |=> !usb_error_flags[`UEF_BIT_MODE_DEP])
    else $error("token check error latched in host mode");

  AST_DEVICE_NO_EOF: assert property (!host_mode && !i_rx.crc5_fail && !usb_error_flags[`UEF_BIT_MODE_DEP] // RULE9
    |=> !usb_error_flags[`UEF_BIT_MODE_DEP])
    else $error("device mode bit set without token error");

  // ----------------------------------------
  // Read path checks
  // ----------------------------------------
  AST_UNMAPPED_ZERO: assert property (s_unmapped_read |=> o_reg_rdata == 32'h00000000) // RULE1
    else $error("unmapped offset read nonzero");

  // Read data must drop back to zero so a stale word is never taken twice
  AST_RDATA_IDLE: assert property (!i_reg_rd |=> o_reg_rdata == 32'h00000000)
    else $error("read data stands without a read");

  AST_CTRL_READ: assert property (i_reg_rd && i_reg_addr == `UEF_OFF_CTRL
    |=> o_reg_rdata == {31'h00000000, $past(host_mode)})
    else $error("control read mismatch");

  AST_STATUS_BUSY: assert property (i_reg_rd && i_reg_addr == `UEF_OFF_STATUS
    |=> o_reg_rdata[`UEF_STAT_FRAME_BUSY] == $past(i_xfer_busy))
    else $error("status busy bit mismatch");

endmodule : uef_error_flags

/* File: logic/uef_pid_checker.sv */
// Packet identifier check against its complement nibble
`timescale 1ns/1ps

module uef_pid_checker (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Received identifier
  input wire logic i_pid_valid,
  input wire logic [7:0] i_pid,
  // Result
  output logic o_pid_err
);

  // ----------------------------------------
  // Complement check
  // ----------------------------------------
  // (RULE10) identifier versus complement
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_pid_err <= 1'b0;
    else
      o_pid_err <= i_pid_valid && (i_pid[7:4] != ~i_pid[3:0]);
  end

  AST_PID_CHECK: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // RULE10
    i_pid_valid && (i_pid[7:4] == ~i_pid[3:0]) |=> !o_pid_err)
    else $error("good identifier flagged");

endmodule : uef_pid_checker

/* File: logic/uef_pkg.sv */
// Types shared by the error flag block
package uef_pkg;

  // ----------------------------------------
  // Event carriers
  // ----------------------------------------
  typedef struct packed {
    logic eop;
    logic expect_reply;
    logic sop;
    logic stuff_err;
    logic partial_byte;
    logic crc16_fail;
    logic crc5_fail;
    logic truncated;
    logic pid_valid;
    logic [7:0] pid;
  } uef_rx_evt_t;

  typedef struct packed {
    logic bdt_base_invalid;
    logic buf_addr_invalid;
    logic grant_late;
  } uef_dma_evt_t;

  typedef enum logic {
    uef_ta_idle,
    uef_ta_wait
  } uef_ta_state_t;

endpackage : uef_pkg

/* File: logic/uef_turnaround_timer.sv */
// Bus turnaround idle timer counted in bit times
`timescale 1ns/1ps
`include "uef_defs.svh"

module uef_turnaround_timer #(
  parameter int LIMIT = `UEF_TURNAROUND_BIT_TIMES,
  parameter int CNT_W = 5
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Link events
  input wire logic i_start,
  input wire logic i_activity,
  input wire logic i_bit_tick,
  // Results
  output logic o_waiting,
  output logic o_timeout
);

  if ((1 << CNT_W) <= LIMIT)
  begin : g_bad_width
    $error("uef_turnaround_timer: CNT_W too small for LIMIT");
  end

  uef_pkg::uef_ta_state_t state;
  logic [CNT_W-1:0] cnt;

  // ----------------------------------------
  // Idle counter
  // ----------------------------------------
  // (RULE6) more than sixteen idle bits
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state <= uef_pkg::uef_ta_idle;
      cnt <= '0;
      o_timeout <= 1'b0;
    end
    else
    begin
      o_timeout <= 1'b0;
      case (state)
        uef_pkg::uef_ta_idle:
        begin
          if (i_start)
          begin
            state <= uef_pkg::uef_ta_wait;
            cnt <= '0;
          end
        end
        uef_pkg::uef_ta_wait:
        begin
          // A new end of packet restarts the count and wins over bus activity, which otherwise ends the wait
          if (i_start)
            cnt <= '0;
          else if (i_activity)
            state <= uef_pkg::uef_ta_idle;
          else if (i_bit_tick)
          begin
            if (cnt == CNT_W'(LIMIT))
            begin
              state <= uef_pkg::uef_ta_idle;
              o_timeout <= 1'b1;
            end
            else
              cnt <= cnt + 1'b1;
          end
        end
        default:
          state <= uef_pkg::uef_ta_idle;
      endcase
    end
  end

  assign o_waiting = (state == uef_pkg::uef_ta_wait);

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  AST_TA_EXCEEDS: assert property ($rose(o_timeout) |-> $past(cnt) == CNT_W'(LIMIT) && $past(i_bit_tick)) // RULE6
    else $error("turnaround time-out before limit");

endmodule : uef_turnaround_timer

/* File: tb/test_usb_error_status_flags.sv */
// Self-checking bench for the error status flag register
`timescale 1ns/1ps
`include "uef_defs.svh"

module test_usb_error_status_flags;
  typedef struct packed {
    logic [3:0] kind;
    logic [7:0] pid;
    logic host;
    logic [7:0] flags;
    logic rej;
  } uef_row_t;

  logic clk;
  logic resetn;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  uef_pkg::uef_rx_evt_t rx;
  uef_pkg::uef_dma_evt_t dma;
  logic tick;
  logic [15:0] sof;
  logic busy;
  logic reject;
  logic host;
  logic [7:0] flags;
  logic req;
  logic [3:0] kind;
  logic [7:0] pid;
  logic rej_seen;
  logic [31:0] rv;
  int bad_count;
  int checks_done;

  // Ordinary cases: event, identifier, mode, expected flags, reject pulse
  uef_row_t rows [12] = '{
    '{4'h0, 8'h00, 1'b0, 8'h80, 1'b1}, '{4'h1, 8'h00, 1'b0, 8'h40, 1'b0},
    '{4'h2, 8'h00, 1'b0, 8'h40, 1'b0}, '{4'h3, 8'h00, 1'b0, 8'h20, 1'b0},
    '{4'h4, 8'h00, 1'b0, 8'h20, 1'b0}, '{4'h5, 8'h00, 1'b0, 8'h08, 1'b0},
    '{4'h6, 8'h00, 1'b0, 8'h04, 1'b1}, '{4'h7, 8'h00, 1'b0, 8'h02, 1'b0},
    '{4'h7, 8'h00, 1'b1, 8'h00, 1'b0}, '{4'h8, 8'h11, 1'b0, 8'h01, 1'b0},
    '{4'h8, 8'hd2, 1'b0, 8'h00, 1'b0}, '{4'h8, 8'h2d, 1'b0, 8'h00, 1'b0}
  };

  uef_error_flags u_uef_error_flags (
    .i_core_clk(clk), .i_resetn(resetn), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_rx(rx), .i_bit_tick(tick),
    .i_dma(dma), .i_sof_count(sof), .i_xfer_busy(busy), .o_packet_reject(reject),
    .o_host_mode(host), .o_flags(flags)
  );

  uef_link_partner u_uef_link_partner (
    .i_core_clk(clk), .i_resetn(resetn), .i_req(req), .i_kind(kind), .i_pid(pid),
    .o_rx(rx), .o_dma(dma), .o_bit_tick(tick)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Reject is a single-cycle pulse, so it is caught here
  always @(posedge clk)
  begin
    if (reject === 1'b1)
      rej_seen <= 1'b1;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task stop_test;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_write

  task reg_read(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask : reg_read

  task fire(input logic [3:0] k, input logic [7:0] p);
    @(posedge clk);
    req <= 1'b1;
    kind <= k;
    pid <= p;
    @(posedge clk);
    req <= 1'b0;
  endtask : fire

  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task wait_flag(input int b);
    int n;
    n = 0;
    while (flags[b] !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 40)
    begin
      bad_count++;
      $display("MISMATCH t=%0t flag %0d never set", $time, b);
      stop_test;
    end
  endtask : wait_flag

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    resetn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    sof = 16'h0;
    busy = 1'b0;
    req = 1'b0;
    kind = 4'h0;
    pid = 8'h00;
    rej_seen = 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    settle(1);
    chk({23'h0, host, flags}, 32'h0);
    reg_read(`UEF_OFF_FLAGS);
    chk(rv, 32'h0);
    foreach (rows[i])
    begin
      reg_write(`UEF_OFF_CTRL, {31'h0, rows[i].host});
      settle(1);
      rej_seen = 1'b0;
      fire(rows[i].kind, rows[i].pid);
      settle(4);
      chk({24'h0, flags}, {24'h0, rows[i].flags});
      chk({31'h0, rej_seen}, {31'h0, rows[i].rej});
      reg_write(`UEF_OFF_FLAGS, 32'hff);
      settle(1);
      chk({24'h0, flags}, 32'h0);
    end
    reg_write(`UEF_OFF_CTRL, 32'h0);
    fire(4'h0, 8'h00);
    fire(4'h5, 8'h00);
    settle(3);
    reg_read(`UEF_OFF_FLAGS);
    chk(rv, 32'h88);
    reg_write(`UEF_OFF_FLAGS, 32'h08);
    reg_write(`UEF_OFF_FLAGS, 32'hffffff00);
    reg_write(`UEF_OFF_FLAGS, 32'h0);
    reg_read(`UEF_OFF_FLAGS);
    chk(rv, 32'h80);
    reg_write(`UEF_OFF_FLAGS, 32'h80);
    reg_read(8'h10);
    chk(rv, 32'h0);
    // Clear write lands in the very cycle the stuff event stands
    fire(4'h0, 8'h00);
    wr <= 1'b1;
    addr <= `UEF_OFF_FLAGS;
    wdata <= 32'h80;
    @(posedge clk);
    wr <= 1'b0;
    settle(1);
    chk({24'h0, flags}, 32'h80);
    reg_write(`UEF_OFF_FLAGS, 32'h80);
    fire(4'h9, 8'h00);
    reg_read(`UEF_OFF_STATUS);
    chk(rv, 32'h1);
    settle(50);
    chk({31'h0, flags[4]}, 32'h0);
    wait_flag(4);
    chk({24'h0, flags}, 32'h10);
    reg_write(`UEF_OFF_FLAGS, 32'hff);
    fire(4'h9, 8'h00);
    settle(20);
    fire(4'ha, 8'h00);
    settle(100);
    chk({24'h0, flags}, 32'h0);
    reg_write(`UEF_OFF_CTRL, 32'h1);
    busy <= 1'b1;
    sof <= 16'h3;
    settle(2);
    chk({31'h0, host}, 32'h1);
    reg_read(`UEF_OFF_STATUS);
    chk(rv, 32'h2);
    reg_read(`UEF_OFF_CTRL);
    chk(rv, 32'h1);
    @(posedge clk);
    sof <= 16'h0;
    settle(3);
    chk({24'h0, flags}, 32'h02);
    reg_write(`UEF_OFF_FLAGS, 32'h02);
    busy <= 1'b0;
    sof <= 16'h3;
    settle(2);
    @(posedge clk);
    sof <= 16'h0;
    settle(3);
    chk({24'h0, flags}, 32'h0);
    // Second reset in mid-run with a flag set and host mode on
    fire(4'h0, 8'h00);
    settle(2);
    chk({24'h0, flags}, 32'h80);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    settle(1);
    chk({23'h0, host, flags}, 32'h0);
    reg_read(`UEF_OFF_FLAGS);
    chk(rv, 32'h0);
    stop_test;
  end
endmodule : test_usb_error_status_flags

/* File: tb/uef_link_partner.sv */
// Far-side link model that raises receiver and memory events on command
`timescale 1ns/1ps

module uef_link_partner (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Command from the bench
  input wire logic i_req,
  input wire logic [3:0] i_kind,
  input wire logic [7:0] i_pid,
  // Events toward the block
  output uef_pkg::uef_rx_evt_t o_rx,
  output uef_pkg::uef_dma_evt_t o_dma,
  output logic o_bit_tick
);
  logic [1:0] tick_cnt;

  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  // Four core cycles per bit time keep idle counts short
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      tick_cnt <= 2'h0;
      o_bit_tick <= 1'b0;
    end
    else
    begin
      tick_cnt <= tick_cnt + 2'h1;
      o_bit_tick <= (tick_cnt == 2'h3);
    end
  end

  // ----------------------------------------
  // Event pulses
  // ----------------------------------------
  // Identifier is zero outside its valid cycle, never a stale value
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rx <= '0;
      o_dma <= '0;
    end
    else
    begin
      o_rx <= '0;
      o_dma <= '0;
      if (i_req)
      begin
        case (i_kind)
          4'h0: o_rx.stuff_err <= 1'b1;
          4'h1: o_dma.bdt_base_invalid <= 1'b1;
          4'h2: o_dma.buf_addr_invalid <= 1'b1;
          4'h3: o_dma.grant_late <= 1'b1;
          4'h4: o_rx.truncated <= 1'b1;
          4'h5: o_rx.partial_byte <= 1'b1;
          4'h6: o_rx.crc16_fail <= 1'b1;
          4'h7: o_rx.crc5_fail <= 1'b1;
          4'h8:
          begin
            o_rx.pid_valid <= 1'b1;
            o_rx.pid <= i_pid;
          end
          4'h9:
          begin
            o_rx.eop <= 1'b1;
            o_rx.expect_reply <= 1'b1;
          end
          4'ha: o_rx.sop <= 1'b1;
          default: o_dma <= '0;
        endcase
      end
    end
  end
endmodule : uef_link_partner
